// File: rtl/gcrc_pkg.sv
package gcrc_pkg;
	// ****************************************
	// Bus addresses and command codes
	// ****************************************
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [7:0] RESET_CODE = 8'h06;
	localparam logic [6:0] OWN_LO_A = 7'h10;
	localparam logic [6:0] OWN_HI_A = 7'h1f;
	localparam logic [6:0] OWN_LO_B = 7'h30;
	localparam logic [6:0] OWN_HI_B = 7'h3f;
	localparam logic [6:0] SIDE_BIT_POS = 7'h05;
	// ****************************************
	// Register space
	// ****************************************
	localparam int REG_COUNT = 16;
	localparam logic [3:0] MODE_IDX = 4'h0;
	localparam logic [3:0] WHITE_R_IDX = 4'h1;
	localparam logic [3:0] WHITE_G_IDX = 4'h2;
	localparam logic [3:0] WHITE_B_IDX = 4'h3;
	localparam logic [7:0] MODE_KEEP_MASK = 8'h10;
	localparam logic [7:0] WHITE_KEEP_MASK = 8'h80;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_MHZ = 125;
	localparam int SCL_MAX_KHZ = 100;
	localparam logic [2:0] BIT_COUNT_MAX = 3'h7;

	typedef enum logic [2:0] {
		GCRC_IDLE, GCRC_ADDR, GCRC_ADDR_ACK, GCRC_DATA, GCRC_DATA_ACK,
		GCRC_IGNORE
	} gcrc_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} gcrc_bus_s;

	typedef struct packed {
		logic sda_out;
		logic sda_oe;
	} gcrc_drive_s;
endpackage : gcrc_pkg

// File: rtl/gcrc_general_call_clear.sv
`timescale 1ns/10ps
// Overview of operation
// [RULE1] Clear only on write to address zero with data byte 0x06.
// [RULE2] Clear clears every colour-adjust register of this controller side.
// [RULE3] Mode bit 4 and white-level bit 7 of each colour survive clear.
// [RULE4] After clear all colour adjustment is disabled; video uncorrected.
// [RULE5] General call address is write only; reads get no acknowledge.
// [RULE6] Own slave addresses are 0x10-0x1f and 0x30-0x3f; code flags only the range whose bit 5 equals SIDE_RIGHT.
// [RULE7] Slave only, up to 100 kHz; never drives the clock line.
// [RULE8] Acknowledge address and data byte; clear right after data byte.
module gcrc_general_call_clear #(
	parameter int REGS = gcrc_pkg::REG_COUNT,
	parameter logic SIDE_RIGHT = 1'b0
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Two-wire bus, sampled synchronously
	input wire gcrc_pkg::gcrc_bus_s bus_in,
	output gcrc_pkg::gcrc_drive_s bus_drive,
	// Register space, written by the regular slave logic
	input wire logic reg_write,
	input wire logic [3:0] reg_index,
	input wire logic [7:0] reg_wdata,
	output logic [REGS*8-1:0] reg_image,
	// Status
	output logic clear_pulse,
	output logic adjust_enabled,
	output logic own_addr_hit
);
	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ****************************************
	// Bus edge detection
	// ****************************************
	// Pins are already synchronous; one stage gives the edge reference
	gcrc_pkg::gcrc_bus_s prev_reg;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '1;
		end else begin
			prev_reg <= bus_in;
		end
	end
	assign scl_rise = bus_in.scl && !prev_reg.scl;
	assign scl_fall = !bus_in.scl && prev_reg.scl;
	assign start_cond = bus_in.scl && prev_reg.scl && prev_reg.sda
		&& !bus_in.sda;
	assign stop_cond = bus_in.scl && prev_reg.scl && !prev_reg.sda
		&& bus_in.sda;

	// ****************************************
	// Byte receiver and general call decode
	// ****************************************
	gcrc_pkg::gcrc_state_e state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [2:0] bit_reg, bit_next;
	logic ack_reg, ack_next;
	logic clear_reg, clear_next;
	logic hit_reg, hit_next;
	logic full_reg, full_next;
	logic [6:0] rx_addr;
	logic own_match;

	assign rx_addr = shift_reg[7:1];
	// Side bit 5 of the address must match this controller
	assign own_match = (((rx_addr >= gcrc_pkg::OWN_LO_A)
		&& (rx_addr <= gcrc_pkg::OWN_HI_A))
		|| ((rx_addr >= gcrc_pkg::OWN_LO_B)
		&& (rx_addr <= gcrc_pkg::OWN_HI_B)))
		&& (rx_addr[gcrc_pkg::SIDE_BIT_POS[2:0]] == SIDE_RIGHT); // RULE6

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_next = bit_reg;
		ack_next = ack_reg;
		clear_next = 1'b0;
		hit_next = 1'b0;
		full_next = full_reg;
		if (start_cond) begin
			state_next = gcrc_pkg::GCRC_ADDR;
			bit_next = 3'h0;
			ack_next = 1'b0;
			full_next = 1'b0;
		end else if (stop_cond) begin
			state_next = gcrc_pkg::GCRC_IDLE;
			ack_next = 1'b0;
			full_next = 1'b0;
		end else begin
			unique case (state_reg)
			gcrc_pkg::GCRC_IDLE, gcrc_pkg::GCRC_IGNORE: begin
				ack_next = 1'b0;
			end
			gcrc_pkg::GCRC_ADDR, gcrc_pkg::GCRC_DATA: begin
				// Count rises: the fall that ends START is no bit
				if (scl_rise) begin
					shift_next = {shift_reg[6:0], bus_in.sda};
					bit_next = bit_reg + 3'h1;
					full_next = (bit_reg
						== gcrc_pkg::BIT_COUNT_MAX);
				end
				if (scl_fall) begin
					if (full_reg) begin
						full_next = 1'b0;
						if (state_reg == gcrc_pkg::GCRC_ADDR) begin
							// Read of address zero is not acknowledged
							if (rx_addr == gcrc_pkg::GEN_CALL_ADDR
								&& !shift_reg[0]) begin // RULE5
								ack_next = 1'b1; // RULE8
								state_next = gcrc_pkg::GCRC_ADDR_ACK;
							end else begin
								hit_next = own_match; // RULE6
								state_next = gcrc_pkg::GCRC_IGNORE;
							end
						end else begin
							ack_next = 1'b1; // RULE8
							state_next = gcrc_pkg::GCRC_DATA_ACK;
							clear_next = (shift_reg
								== gcrc_pkg::RESET_CODE); // RULE1
						end
					end
				end
			end
			gcrc_pkg::GCRC_ADDR_ACK, gcrc_pkg::GCRC_DATA_ACK: begin
				if (scl_fall) begin
					ack_next = 1'b0;
					bit_next = 3'h0;
					// Further bytes after the code are ignored
					state_next = (state_reg == gcrc_pkg::GCRC_ADDR_ACK)
						? gcrc_pkg::GCRC_DATA : gcrc_pkg::GCRC_IGNORE;
				end
			end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= gcrc_pkg::GCRC_IDLE;
			shift_reg <= 8'h00;
			bit_reg <= 3'h0;
			ack_reg <= 1'b0;
			clear_reg <= 1'b0;
			hit_reg <= 1'b0;
			full_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bit_reg <= bit_next;
			ack_reg <= ack_next;
			clear_reg <= clear_next;
			hit_reg <= hit_next;
			full_reg <= full_next;
		end
	end

	// ****************************************
	// Acknowledge drive
	// ****************************************
	// Open drain: only ever pull SDA low, SCL is never driven
	assign bus_drive.sda_out = 1'b0; // RULE7
	assign bus_drive.sda_oe = ack_reg; // RULE8
	assign clear_pulse = clear_reg;
	assign own_addr_hit = hit_reg;

	// ****************************************
	// Colour-adjust register space
	// ****************************************
	logic [7:0] regs_reg [REGS];
	logic [7:0] regs_next [REGS];
	logic [REGS-1:0] live;
	for (genvar i = 0; i < REGS; i++) begin : g_reg
		localparam logic [7:0] KEEP = (i == int'(gcrc_pkg::MODE_IDX))
			? gcrc_pkg::MODE_KEEP_MASK
			: ((i >= int'(gcrc_pkg::WHITE_R_IDX)
			&& i <= int'(gcrc_pkg::WHITE_B_IDX))
			? gcrc_pkg::WHITE_KEEP_MASK : 8'h00);
		always_comb begin
			regs_next[i] = regs_reg[i];
			// Clear takes priority over a coincident software write
			if (clear_reg) begin
				regs_next[i] = regs_reg[i] & KEEP; // RULE2 RULE3
			end else if (reg_write && reg_index == 4'(i)) begin
				regs_next[i] = reg_wdata;
			end
		end
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				regs_reg[i] <= gcrc_pkg::REG_RESET;
			end else begin
				regs_reg[i] <= regs_next[i];
			end
		end
		assign reg_image[i*8 +: 8] = regs_reg[i];
		assign live[i] = (regs_reg[i] & ~KEEP) != 8'h00; // RULE4
	end

	// ****************************************
	// Correction enable
	// ****************************************
	// Kept bits alone never switch correction back on
	always_comb begin
		adjust_enabled = 1'b0;
		for (int i = 0; i < REGS; i++) begin
			if (live[i]) begin
				adjust_enabled = 1'b1; // RULE4
			end
		end
	end
endmodule : gcrc_general_call_clear

// File: test/gcrc_chk_asserts.sv
`timescale 1ns/10ps
module gcrc_chk #(parameter int REGS = 16) (
	// Watched ports
	input wire logic clock,
	input wire logic resetn,
	input wire gcrc_pkg::gcrc_bus_s bus_in,
	input wire gcrc_pkg::gcrc_drive_s bus_drive,
	input wire logic [REGS*8-1:0] reg_image,
	input wire logic clear_pulse,
	input wire logic adjust_enabled,
	input wire logic own_addr_hit
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_clr; clear_pulse; endsequence
	property p_low; bus_drive.sda_out == 1'b0; endproperty
	a_low: assert property (p_low) else $error("sda high");
	property p_one; s_clr |=> !clear_pulse; endproperty
	a_one: assert property (p_one) else $error("long clear");
	property p_off; s_clr |=> !adjust_enabled && reg_image[14:8] == 7'h00;
	endproperty
	a_off: assert property (p_off) else $error("not cleared");
	property p_keep; s_clr |=> reg_image[4] == $past(reg_image[4])
		&& reg_image[31] == $past(reg_image[31]); endproperty
	a_keep: assert property (p_keep) else $error("kept bit lost");
	// Ack may only move while the clock line is low
	property p_rise; $rose(bus_drive.sda_oe) |-> !bus_in.scl; endproperty
	a_rise: assert property (p_rise) else $error("ack edge");
	property p_hold; bus_drive.sda_oe && bus_in.scl |=> bus_drive.sda_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("ack dropped");
	property p_ack; s_clr |-> ##[0:2] bus_drive.sda_oe; endproperty
	a_ack: assert property (p_ack) else $error("data not acked");
	property p_hit; own_addr_hit |=> !own_addr_hit; endproperty
	a_hit: assert property (p_hit) else $error("long hit");
endmodule : gcrc_chk
bind gcrc_general_call_clear gcrc_chk #(.REGS(REGS)) i_gcrc_chk (
	.clock(clock), .resetn(resetn), .bus_in(bus_in), .bus_drive(bus_drive),
	.reg_image(reg_image), .clear_pulse(clear_pulse),
	.adjust_enabled(adjust_enabled), .own_addr_hit(own_addr_hit));

// File: test/gcrc_master.sv
`timescale 1ns/10ps
module gcrc_master (
	// Clock and bus lines
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	// ********
	// Bus master
	// ********
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task w(input int n);
		repeat (n) @(negedge clock);
	endtask : w
	task start;
		w(4);
		sda_m = 1'b0;
		w(4);
		scl = 1'b0;
		w(1);
	endtask : start
	task stop;
		sda_m = 1'b0;
		w(3);
		scl = 1'b1;
		w(4);
		sda_m = 1'b1;
	endtask : stop
	// Data moves one cycle after the fall, never with it
	task wbyte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i == 0) ? 1'b1 : b[7];
			b = b << 1;
			w(3);
			scl = 1'b1;
			w(2);
			ack = !sda;
			w(2);
			scl = 1'b0;
			w(1);
		end
	endtask : wbyte
endmodule : gcrc_master

// File: test/gcrc_general_call_clear_tb_top.sv
`timescale 1ns/10ps
module gcrc_general_call_clear_tb_top;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic reg_write = 1'b0;
	logic [3:0] reg_index = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic scl, sda_m, sda, clear_pulse, adjust_enabled, own_addr_hit;
	logic clear_seen, hit_seen;
	logic [1:0] a;
	logic [127:0] reg_image;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int clears = 0;
	int hits = 0;
	gcrc_pkg::gcrc_bus_s bus_in;
	gcrc_pkg::gcrc_drive_s bus_drive;
	// ********
	// Bench
	// ********
	assign sda = sda_m & !bus_drive.sda_oe;
	assign bus_in = {scl, sda};
	gcrc_master i_gcrc_master (.clock(clock), .sda(sda), .scl(scl),
		.sda_m(sda_m));
	gcrc_general_call_clear i_gcrc_general_call_clear (.clock(clock),
		.resetn(resetn), .bus_in(bus_in), .bus_drive(bus_drive),
		.reg_write(reg_write), .reg_index(reg_index), .reg_wdata(reg_wdata),
		.reg_image(reg_image), .clear_pulse(clear_pulse),
		.adjust_enabled(adjust_enabled), .own_addr_hit(own_addr_hit));
	initial forever #4 clock = ~clock;
	// Pulses counted mid-cycle, away from the launching edge
	always @(negedge clock) begin
		cycles++;
		if (clear_pulse === 1'b1) clears++;
		if (own_addr_hit === 1'b1) hits++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	task chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	task fill;
		for (int i = 0; i < 16; i++) begin
			@(negedge clock);
			reg_write = 1'b1;
			reg_index = i[3:0];
			reg_wdata = 8'hff;
		end
		@(negedge clock);
		reg_write = 1'b0;
	endtask : fill
	task xfer(input logic [7:0] ad, d, input logic two);
		int c0, h0;
		a = 2'b00;
		c0 = clears;
		h0 = hits;
		i_gcrc_master.start();
		i_gcrc_master.wbyte(ad, a[1]);
		if (two) i_gcrc_master.wbyte(d, a[0]);
		i_gcrc_master.stop();
		clear_seen = (clears != c0);
		hit_seen = (hits != h0);
	endtask : xfer
	task t_clear;
		fill();
		xfer(8'h00, 8'h06, 1'b1);
		chk(a, 2'b11);
		chk(clear_seen, 1'b1);
		chk(reg_image[31:0], 32'h80808010);
		chk({31'h0, |reg_image[127:32]}, 32'h0);
		chk(adjust_enabled, 1'b0);
		$display("clear test done");
	endtask : t_clear
	task t_code;
		fill();
		xfer(8'h00, 8'h07, 1'b1);
		chk(a, 2'b11);
		chk(clear_seen, 1'b0);
		chk(reg_image[31:0], 32'hffffffff);
		chk(adjust_enabled, 1'b1);
		$display("code test done");
	endtask : t_code
	task t_read;
		xfer(8'h01, 8'h00, 1'b0);
		chk(a, 2'b00);
		$display("read test done");
	endtask : t_read
	task t_own;
		logic [6:0] ad [5] = '{7'h10, 7'h1f, 7'h30, 7'h0f, 7'h20};
		logic [4:0] ex = 5'b11000;
		for (int i = 0; i < 5; i++) begin
			xfer({ad[i], 1'b0}, 8'h00, 1'b0);
			chk(hit_seen, ex[4-i]);
		end
		$display("address test done");
	endtask : t_own
	task summarize;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		repeat (4) @(negedge clock);
		t_clear();
		t_code();
		t_read();
		t_own();
		summarize();
	end
endmodule : gcrc_general_call_clear_tb_top
